// *** shared/wps_map.svh ***
`ifndef WPS_MAP_SVH
`define WPS_MAP_SVH
// Register byte offsets
`define WPS_A_GMODE 8'h00
`define WPS_A_RMODE 8'h04
`define WPS_A_RCNT  8'h08
`define WPS_A_CMD   8'h0C
`define WPS_A_SLOT  8'h10
`define WPS_A_ALEN  8'h14
`define WPS_A_STAT  8'h18
`define WPS_A_WPOS  8'h1C
`define WPS_A_FREE  8'h20
`define WPS_A_POS   8'h24
`define WPS_A_DATA  8'h28
`define WPS_A_IDLE  8'h2C
`define WPS_A_CFG   8'h30
`define WPS_A_PSEL  8'h34
// Mode and reference codes
`define WPS_GEN_WAVE   8'h0E
`define WPS_GEN_SCRIPT 8'h0F
`define WPS_REP_FIN    8'h10
`define WPS_REP_CONT   8'h11
`define WPS_POS_START  8'h2C
`define WPS_POS_CUR    8'h2D
// Reset values
`define WPS_RST_COUNT 32'h0000_0001
// Command codes in CMD[2:0]
`define WPS_OP_START 3'h1
`define WPS_OP_ABORT 3'h2
`define WPS_OP_ALLOC 3'h3
`define WPS_OP_FREE  3'h4
`define WPS_OP_CLR   3'h5
// Error causes in STATUS[6:4]
`define WPS_E_ALLOC 3'h1
`define WPS_E_FREE  3'h2
`define WPS_E_POS   3'h3
`define WPS_E_DATA  3'h4
`define WPS_E_START 3'h5
// Sizes
`define WPS_DEPTH 11'h400
`define WPS_NSLOT 4
`define WPS_FIFO_DEPTH 32
// Sample width masks and bus response codes
`define WPS_MASK32 32'hFFFF_FFFF
`define WPS_MASK16 32'h0000_FFFF
`define WPS_MASK8  32'h0000_00FF
`define WPS_OKAY   2'b00
`define WPS_SLVERR 2'b10
`endif

// *** shared/wps_pkg.sv ***
package wps_pkg;
	typedef logic [31:0] wps_word_t;
	typedef logic [9:0]  wps_addr_t;
	typedef logic [10:0] wps_len_t;
	typedef enum logic [1:0]
	{
		PB_IDLE = 2'b00,
		PB_PLAY = 2'b01
	} wps_pb_t;
endpackage

// *** rtl/wps_top.sv ***
// Notes on behaviour
// - Mode code 14 plays a named waveform, 15 a script; reset selects 14.
// - Finite mode 16 plays the waveform repetition_count times, then stops.
// - Continuous mode 17 loops until abort; count is ignored.
// - Reset gives finite mode and a count of one.
// - Repetition settings only matter in waveform mode.
// - Each waveform is one contiguous region; no resize, free then reallocate.
// - Allocation larger than free memory errors and reserves nothing.
// - Stored sample is 32 bits, or 16 narrow single_rate, or 8 narrow double rate.
// - Reference 44 counts from start, 45 from current position; default 45, zero.
// - A position before the first sample errors and leaves position unchanged.
// - A position past the region end errors.
// - Data writes start at the write position and overwrite samples there.
// - After each write the position moves past the last sample written, unless an allocate, free or position command is taken in that cycle.
// - Freed or unallocated names raise errors; scripts are not checked at start.
// - A normally finished generation drives the idle levels.

`include "wps_map.svh"

module wps_fifo #(
	parameter int W = 32,
	parameter int D = 32
) (
	input  wire logic         aclk,      // Clock
	input  wire logic         aresetn,   // Sync reset, low
	input  wire logic         ce,        // Clock enable
	input  wire logic [W-1:0] in_data,   // Fill data
	input  wire logic         in_valid,  // Fill valid
	output logic              in_ready,  // Not full
	output logic [W-1:0]      out_data,  // Head word
	output logic              out_valid, // Not empty
	input  wire logic         out_ready  // Drain accepts
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	// Handshake terms
	assign in_ready  = (cnt_q != D[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;

	// Storage
	always_ff @(posedge aclk)
	begin
		if (ce && push)
			mem[wp_q] <= in_data;
	end

	// Pointers and level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else if (ce)
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

module wps_top (
	input  wire logic              aclk,          // 100 MHz clock
	input  wire logic              aresetn,       // Sync reset, low
	input  wire logic              ce,            // Clock enable
	input  wire logic [7:0]        s_awaddr,      // Write address
	input  wire logic              s_awvalid,     // Write address valid
	output logic                   s_awready,     // Write address ready
	input  wire wps_pkg::wps_word_t s_wdata,      // Write data
	input  wire logic [3:0]        s_wstrb,       // Byte enables
	input  wire logic              s_wvalid,      // Write data valid
	output logic                   s_wready,      // Write data ready
	output logic [1:0]             s_bresp,       // Write response
	output logic                   s_bvalid,      // Write response valid
	input  wire logic              s_bready,      // Response ready
	input  wire logic [7:0]        s_araddr,      // Read address
	input  wire logic              s_arvalid,     // Read address valid
	output logic                   s_arready,     // Read address ready
	output wps_pkg::wps_word_t     s_rdata,       // Read data
	output logic [1:0]             s_rresp,       // Read response
	output logic                   s_rvalid,      // Read data valid
	input  wire logic              s_rready,      // Read ready
	output wps_pkg::wps_word_t     pattern_out,   // Generated pattern
	output logic                   pattern_valid, // Sample from memory
	output logic                   gen_active,    // Generation running
	output logic                   script_start   // Pulse to script engine
);
	import wps_pkg::*;

	logic [7:0] gmode_q;
	logic [7:0] rmode_q;
	logic [31:0] rcnt_q;
	logic [1:0] slot_q;
	logic [2:0] psel_q;
	wps_len_t alen_q;
	wps_word_t idle_q;
	logic [1:0] cfg_q;
	logic bvalid_q, rvalid_q, awr_q, arr_q;
	logic [1:0] bresp_q, rresp_q;
	wps_word_t rdata_q;
	logic wfire, rfire, hit_w, hit_r;
	logic [2:0] op;
	wps_addr_t base_q [`WPS_NSLOT];
	wps_len_t len_q [`WPS_NSLOT];
	wps_len_t wpos_q [`WPS_NSLOT];
	logic [`WPS_NSLOT-1:0] res_q;
	wps_len_t top_q;
	logic tbl_err_q;
	logic [2:0] tbl_code_q;
	logic err_q;
	logic [2:0] code_q;
	wps_word_t fifo_dout;
	logic fifo_in_ready, fifo_valid, drain;
	logic signed [16:0] npos;
	wps_word_t mem [`WPS_DEPTH];
	wps_pb_t pb_q;
	logic [1:0] pslot_q;
	wps_len_t idx_q;
	logic [31:0] left_q;
	logic st_err_q;
	logic [1:0] pick;
	logic pick_ok;
	logic [2:0] nres;

	// Merges a register word with byte enables
	function automatic wps_word_t merge(input wps_word_t o, input wps_word_t n, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[8*i +: 8] = n[8*i +: 8];
		return o;
	endfunction

	// Known register decode
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= `WPS_A_PSEL);
	endfunction

	// Sample width per variant and rate
	function automatic wps_word_t smask(input logic [1:0] c);
		if (!c[0])
			return `WPS_MASK32;
		return c[1] ? `WPS_MASK8 : `WPS_MASK16;
	endfunction

	assign hit_w = mapped(s_awaddr);
	assign hit_r = mapped(s_araddr);
	assign wfire = s_awvalid && s_awready && s_wvalid && s_wready;
	assign rfire = s_arvalid && s_arready;
	assign op = s_wdata[2:0];
	assign s_awready = awr_q;
	assign s_wready  = awr_q;
	assign s_bvalid  = bvalid_q;
	assign s_bresp   = bresp_q;
	assign s_arready = arr_q;
	assign s_rvalid  = rvalid_q;
	assign s_rresp   = rresp_q;
	assign s_rdata   = rdata_q;

	// Write channel: take address and data together, stall data while full
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awr_q    <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= `WPS_OKAY;
		end
		else if (ce)
		begin
			awr_q <= !awr_q && !bvalid_q && s_awvalid && s_wvalid
				&& (s_awaddr != `WPS_A_DATA || fifo_in_ready);
			if (wfire)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= hit_w ? `WPS_OKAY : `WPS_SLVERR;
			end
			else if (s_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gmode_q <= `WPS_GEN_WAVE;
			rmode_q <= `WPS_REP_FIN;
			rcnt_q  <= `WPS_RST_COUNT;
			slot_q  <= '0;
			psel_q  <= '0;
			alen_q  <= '0;
			idle_q  <= '0;
			cfg_q   <= '0;
		end
		else if (ce && wfire)
		begin
			case (s_awaddr)
				`WPS_A_GMODE: gmode_q <= 8'(merge({24'h00_0000, gmode_q}, s_wdata, s_wstrb));
				`WPS_A_RMODE: rmode_q <= 8'(merge({24'h00_0000, rmode_q}, s_wdata, s_wstrb));
				`WPS_A_RCNT:  rcnt_q  <= merge(rcnt_q, s_wdata, s_wstrb);
				`WPS_A_SLOT:  slot_q  <= s_wdata[1:0];
				`WPS_A_PSEL:  psel_q  <= {s_wdata[8], s_wdata[1:0]};
				`WPS_A_ALEN:  alen_q  <= s_wdata[10:0];
				`WPS_A_IDLE:  idle_q  <= merge(idle_q, s_wdata, s_wstrb);
				`WPS_A_CFG:   cfg_q   <= s_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arr_q    <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q  <= `WPS_OKAY;
			rdata_q  <= '0;
		end
		else if (ce)
		begin
			arr_q <= !arr_q && !rvalid_q && s_arvalid;
			if (rfire)
			begin
				rvalid_q <= 1'b1;
				rresp_q  <= hit_r ? `WPS_OKAY : `WPS_SLVERR;
				case (s_araddr)
					`WPS_A_GMODE: rdata_q <= {24'h00_0000, gmode_q};
					`WPS_A_RMODE: rdata_q <= {24'h00_0000, rmode_q};
					`WPS_A_RCNT:  rdata_q <= rcnt_q;
					`WPS_A_SLOT:  rdata_q <= {30'h0000_0000, slot_q};
					`WPS_A_PSEL:  rdata_q <= {23'h00_0000, psel_q[2], 6'h00, psel_q[1:0]};
					`WPS_A_ALEN:  rdata_q <= {21'h00_0000, alen_q};
					`WPS_A_STAT:  rdata_q <= {20'h0_0000, res_q, 1'b0, code_q, 2'b00, err_q, gen_active};
					`WPS_A_WPOS:  rdata_q <= {21'h00_0000, wpos_q[slot_q]};
					`WPS_A_FREE:  rdata_q <= {21'h00_0000, `WPS_DEPTH - top_q};
					`WPS_A_IDLE:  rdata_q <= idle_q;
					`WPS_A_CFG:   rdata_q <= {30'h0000_0000, cfg_q};
					default:      rdata_q <= '0;
				endcase
			end
			else if (s_rready)
				rvalid_q <= 1'b0;
		end
	end

	// Write data buffer between the bus and sample memory
	wps_fifo #(
		.W(32),
		.D(`WPS_FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.in_data   (s_wdata),
		.in_valid  (wfire && s_awaddr == `WPS_A_DATA),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_dout),
		.out_valid (fifo_valid),
		.out_ready (drain)
	);

	// Drain only while memory is not being played
	assign drain = fifo_valid && (pb_q == PB_IDLE);

	// New write position from reference and signed offset
	always_comb
	begin
		npos = {{1'b0}, {5'h00}, wpos_q[slot_q]} + {s_wdata[15], s_wdata[15:0]};
		if (s_wdata[23:16] == `WPS_POS_START)
			npos = {s_wdata[15], s_wdata[15:0]};
	end

	// Region table: allocate, free, position and data advance
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			res_q      <= '0;
			top_q      <= '0;
			tbl_err_q  <= 1'b0;
			tbl_code_q <= '0;
			for (int i = 0; i < `WPS_NSLOT; i++)
			begin
				base_q[i] <= '0;
				len_q[i]  <= '0;
				wpos_q[i] <= '0;
			end
		end
		else if (ce)
		begin
			tbl_err_q <= 1'b0;
			if (wfire && s_awaddr == `WPS_A_CMD && op == `WPS_OP_ALLOC)
			begin
				if (res_q[slot_q] || alen_q > `WPS_DEPTH - top_q)
				begin
					tbl_err_q  <= 1'b1;
					tbl_code_q <= `WPS_E_ALLOC;
				end
				else
				begin
					res_q[slot_q]  <= 1'b1;
					base_q[slot_q] <= top_q[9:0];
					len_q[slot_q]  <= alen_q;
					wpos_q[slot_q] <= '0;
					top_q          <= top_q + alen_q;
				end
			end
			else if (wfire && s_awaddr == `WPS_A_CMD && op == `WPS_OP_FREE)
			begin
				if (!res_q[slot_q] || (pb_q == PB_PLAY && pslot_q == slot_q))
				begin
					tbl_err_q  <= 1'b1;
					tbl_code_q <= `WPS_E_FREE;
				end
				else
				begin
					res_q[slot_q] <= 1'b0;
					if ({1'b0, base_q[slot_q]} + len_q[slot_q] == top_q)
						top_q <= {1'b0, base_q[slot_q]};
				end
			end
			else if (wfire && s_awaddr == `WPS_A_POS)
			begin
				if (!res_q[slot_q] || npos < 0 || npos > $signed({6'h00, len_q[slot_q]}))
				begin
					tbl_err_q  <= 1'b1;
					tbl_code_q <= `WPS_E_POS;
				end
				else
					wpos_q[slot_q] <= npos[10:0];
			end
			else if (drain)
			begin
				if (!res_q[slot_q] || wpos_q[slot_q] >= len_q[slot_q])
				begin
					tbl_err_q  <= 1'b1;
					tbl_code_q <= `WPS_E_DATA;
				end
				else
					wpos_q[slot_q] <= wpos_q[slot_q] + 11'h001;
			end
		end
	end

	// Sample memory write at the current position
	always_ff @(posedge aclk)
	begin
		if (ce && drain && res_q[slot_q] && wpos_q[slot_q] < len_q[slot_q])
			mem[base_q[slot_q] + wpos_q[slot_q][9:0]] <= fifo_dout & smask(cfg_q);
	end

	// Waveform chosen at start
	always_comb
	begin
		nres = '0;
		pick = '0;
		for (int i = 0; i < `WPS_NSLOT; i++)
			if (res_q[i])
			begin
				nres = nres + 3'h1;
				pick = i[1:0];
			end
		pick_ok = (nres == 3'h1);
		if (psel_q[2])
		begin
			pick    = psel_q[1:0];
			pick_ok = res_q[psel_q[1:0]];
		end
	end

	// Playback sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pb_q          <= PB_IDLE;
			pslot_q       <= '0;
			idx_q         <= '0;
			left_q        <= '0;
			st_err_q      <= 1'b0;
			script_start  <= 1'b0;
			gen_active    <= 1'b0;
			pattern_valid <= 1'b0;
			pattern_out   <= '0;
		end
		else if (ce)
		begin
			st_err_q     <= 1'b0;
			script_start <= 1'b0;
			case (pb_q)
				PB_IDLE:
				begin
					pattern_valid <= 1'b0;
					pattern_out   <= idle_q;
					if (wfire && s_awaddr == `WPS_A_CMD && op == `WPS_OP_START)
					begin
						if (gmode_q == `WPS_GEN_SCRIPT)
							script_start <= 1'b1;
						else if (!pick_ok)
							st_err_q <= 1'b1;
						else if (len_q[pick] != '0 && (rmode_q == `WPS_REP_CONT || rcnt_q != '0))
						begin
							pb_q       <= PB_PLAY;
							gen_active <= 1'b1;
							pslot_q    <= pick;
							idx_q      <= '0;
							left_q     <= rcnt_q;
						end
					end
				end
				PB_PLAY:
				begin
					pattern_valid <= 1'b1;
					pattern_out   <= mem[base_q[pslot_q] + idx_q[9:0]];
					idx_q         <= idx_q + 11'h001;
					if (wfire && s_awaddr == `WPS_A_CMD && op == `WPS_OP_ABORT)
					begin
						pb_q       <= PB_IDLE;
						gen_active <= 1'b0;
					end
					else if (idx_q + 11'h001 == len_q[pslot_q])
					begin
						idx_q <= '0;
						if (rmode_q != `WPS_REP_CONT)
						begin
							left_q <= left_q - 32'h0000_0001;
							if (left_q == 32'h0000_0001)
							begin
								pb_q       <= PB_IDLE;
								gen_active <= 1'b0;
							end
						end
					end
				end
				default:
					pb_q <= PB_IDLE;
			endcase
		end
	end

	// Sticky error: a new error wins over a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			err_q  <= 1'b0;
			code_q <= '0;
		end
		else if (ce)
		begin
			if (tbl_err_q || st_err_q)
			begin
				err_q  <= 1'b1;
				code_q <= tbl_err_q ? tbl_code_q : `WPS_E_START;
			end
			else if (wfire && s_awaddr == `WPS_A_CMD && op == `WPS_OP_CLR)
				err_q <= 1'b0;
		end
	end
endmodule

// *** dv/wps_top_asserts.sv ***
module wps_top_asserts (
	input wire logic               aclk,          // Clock
	input wire logic               aresetn,       // Reset, low
	input wire logic               s_awvalid,     // Aw valid
	input wire logic               s_awready,     // Aw ready
	input wire logic               s_bvalid,      // B valid
	input wire logic               s_bready,      // B ready
	input wire logic [1:0]         s_bresp,       // B code
	input wire logic               s_arvalid,     // Ar valid
	input wire logic               s_arready,     // Ar ready
	input wire logic               s_rvalid,      // R valid
	input wire logic               s_rready,      // R ready
	input wire wps_pkg::wps_word_t s_rdata,       // R data
	input wire logic               pattern_valid, // Sample out
	input wire logic               gen_active,    // Playing
	input wire logic               script_start   // Script pulse
);
	import wps_pkg::*;
	// One clock domain, one reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_script_pulse;
		script_start |=> !script_start;
	endproperty
	a_script_pulse: assert property (p_script_pulse) else $error("script pulse too long");
	property p_script_quiet;
		script_start |-> !gen_active && !pattern_valid;
	endproperty
	a_script_quiet: assert property (p_script_quiet) else $error("samples in script mode");
	property p_sample_in_gen;
		pattern_valid |-> $past(gen_active);
	endproperty
	a_sample_in_gen: assert property (p_sample_in_gen) else $error("sample outside play");
	property p_first_sample;
		$rose(gen_active) |=> pattern_valid;
	endproperty
	a_first_sample: assert property (p_first_sample) else $error("no first sample");
	property p_idle_after;
		!gen_active && !$past(gen_active) |-> !pattern_valid;
	endproperty
	a_idle_after: assert property (p_idle_after) else $error("sample while idle");
	property p_b_after;
		s_awvalid && s_awready |=> s_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write not answered");
	property p_b_hold;
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_after;
		s_arvalid && s_arready |=> s_rvalid;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read not answered");
	property p_r_hold;
		s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
endmodule

bind wps_top wps_top_asserts u_chk (.aclk, .aresetn, .s_awvalid, .s_awready, .s_bvalid, .s_bready, .s_bresp,
	.s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .pattern_valid, .gen_active, .script_start);

// *** dv/wps_host.sv ***
module wps_host (
	input wire logic               aclk,      // Clock
	output logic [7:0]             s_awaddr,  // Aw address
	output logic                   s_awvalid, // Aw valid
	input wire logic               s_awready, // Aw ready
	output wps_pkg::wps_word_t     s_wdata,   // W data
	output logic [3:0]             s_wstrb,   // W strobes
	output logic                   s_wvalid,  // W valid
	input wire logic               s_wready,  // W ready
	input wire logic [1:0]         s_bresp,   // B code
	input wire logic               s_bvalid,  // B valid
	output logic                   s_bready,  // B ready
	output logic [7:0]             s_araddr,  // Ar address
	output logic                   s_arvalid, // Ar valid
	input wire logic               s_arready, // Ar ready
	input wire wps_pkg::wps_word_t s_rdata,   // R data
	input wire logic [1:0]         s_rresp,   // R code
	input wire logic               s_rvalid,  // R valid
	output logic                   s_rready   // R ready
);
	import wps_pkg::*;
	logic lag; // Raise ready one cycle after the answer
	// Idle bus at time zero
	initial
	begin
		lag = 1'b0;
		{s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
		{s_araddr, s_arvalid, s_rready} = '0;
	end
	// One write, address and data together
	task automatic wr(input logic [7:0] a, input wps_word_t d, output logic [1:0] r);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hF;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= !lag;
		do @(posedge aclk); while (!(s_awready && s_wready));
		s_awvalid <= 1'b0;
		s_wvalid <= 1'b0;
		do @(posedge aclk); while (!s_bvalid);
		if (lag)
		begin
			s_bready <= 1'b1;
			@(posedge aclk);
		end
		r = s_bresp;
		s_bready <= 1'b0;
	endtask
	// One read
	task automatic rd(input logic [7:0] a, output wps_word_t d, output logic [1:0] r);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= !lag;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_rvalid);
		if (lag)
		begin
			s_rready <= 1'b1;
			@(posedge aclk);
		end
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask
endmodule

// *** dv/tb_wps_top.sv ***
`include "wps_map.svh"
module tb_wps_top;
	timeunit 1ns;
	timeprecision 1ns;
	import wps_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_awaddr, s_araddr;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready, pattern_valid, gen_active, script_start;
	wps_word_t s_wdata, s_rdata, pattern_out;
	wps_word_t sq[$];
	int failures, checked, cyc, pulses;
	wps_word_t s_rdata_unused;

	always #5 aclk = ~aclk;

	wps_top dut (.aclk, .aresetn, .ce(1'b1), .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
		.s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .pattern_out, .pattern_valid, .gen_active, .script_start);
	wps_host host (.aclk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
		.s_rready);

	// Timeout, sample capture and script pulse count
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			close_out();
		end
		if (aresetn && pattern_valid === 1'b1) sq.push_back(pattern_out);
		if (script_start === 1'b1) pulses++;
	end

	task automatic close_out();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input wps_word_t e, input wps_word_t g);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input wps_word_t d);
		logic [1:0] r;
		host.wr(a, d, r);
	endtask
	task automatic rc(input string n, input logic [7:0] a, input wps_word_t e);
		wps_word_t d;
		logic [1:0] r;
		host.rd(a, d, r);
		chk(n, e, d);
	endtask
	// Expect the sticky error with its cause, then clear it
	task automatic err(input logic [2:0] c);
		wps_word_t d;
		logic [1:0] r;
		host.rd(`WPS_A_STAT, d, r);
		chk("error", {28'h0, c, 1'b1}, {28'h0, d[6:4], d[1]});
		w(`WPS_A_CMD, {29'h0, `WPS_OP_CLR});
	endtask
	// Write position from a reference code and a signed offset
	task automatic pos(input logic [7:0] rf, input logic [15:0] off);
		w(`WPS_A_POS, {8'h00, rf, off});
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 500 && gen_active !== 1'b0; i++) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask

	task automatic t_reset();
		logic [1:0] r;
		rc("gmode", `WPS_A_GMODE, 32'h0000_000E);
		rc("rmode", `WPS_A_RMODE, 32'h0000_0010);
		rc("rcnt", `WPS_A_RCNT, 32'h0000_0001);
		rc("wpos", `WPS_A_WPOS, 32'h0000_0000);
		rc("free", `WPS_A_FREE, 32'h0000_0400);
		host.rd(8'h38, s_rdata_unused, r);
		chk("rresp", 32'h0000_0002, {30'h0, r});
		host.wr(8'h3C, 32'h0000_0000, r);
		chk("bresp", 32'h0000_0002, {30'h0, r});
	endtask
	task automatic t_fill();
		w(`WPS_A_SLOT, 32'h0000_0000);
		w(`WPS_A_ALEN, 32'h0000_0040);
		w(`WPS_A_CMD, {29'h0, `WPS_OP_ALLOC});
		rc("free", `WPS_A_FREE, 32'h0000_03C0);
		w(`WPS_A_SLOT, 32'h0000_0001);
		w(`WPS_A_ALEN, 32'h0000_03E8);
		w(`WPS_A_CMD, {29'h0, `WPS_OP_ALLOC});
		err(`WPS_E_ALLOC);
		rc("free", `WPS_A_FREE, 32'h0000_03C0);
		w(`WPS_A_SLOT, 32'h0000_0000);
		w(`WPS_A_DATA, 32'h0000_00A0);
		w(`WPS_A_DATA, 32'h0000_00A1);
		rc("wpos", `WPS_A_WPOS, 32'h0000_0002);
		pos(`WPS_POS_START, 16'h0020);
		rc("wpos", `WPS_A_WPOS, 32'h0000_0020);
		pos(`WPS_POS_CUR, 16'hFFE0);
		rc("wpos", `WPS_A_WPOS, 32'h0000_0000);
		w(`WPS_A_CFG, 32'h0000_0001);
		w(`WPS_A_DATA, 32'h1234_5678);
		pos(`WPS_POS_START, 16'h0020);
		w(`WPS_A_CFG, 32'h0000_0003);
		w(`WPS_A_DATA, 32'h1234_5678);
		w(`WPS_A_CFG, 32'h0000_0000);
		rc("wpos", `WPS_A_WPOS, 32'h0000_0021);
		pos(`WPS_POS_START, 16'hFFE0);
		err(`WPS_E_POS);
		rc("wpos", `WPS_A_WPOS, 32'h0000_0021);
		pos(`WPS_POS_START, 16'h0060);
		err(`WPS_E_POS);
	endtask
	// One resident waveform and no selection made
	task automatic t_finite();
		w(`WPS_A_IDLE, 32'h5A5A_5A5A);
		w(`WPS_A_RCNT, 32'h0000_0002);
		sq.delete();
		w(`WPS_A_CMD, {29'h0, `WPS_OP_START});
		wait_idle();
		chk("count", 32'd128, 32'(sq.size()));
		chk("s0", 32'h0000_5678, sq[0]);
		chk("s1", 32'h0000_00A1, sq[1]);
		chk("s32", 32'h0000_0078, sq[32]);
		chk("s64", 32'h0000_5678, sq[64]);
		chk("idle", 32'h5A5A_5A5A, pattern_out);
	endtask
	task automatic t_cont();
		host.lag = 1'b1;
		w(`WPS_A_RMODE, 32'h0000_0011);
		w(`WPS_A_RCNT, 32'h0000_0000);
		sq.delete();
		w(`WPS_A_CMD, {29'h0, `WPS_OP_START});
		repeat (200) @(posedge aclk);
		chk("active", 32'h1, {31'h0, gen_active});
		chk("many", 32'h1, 32'(sq.size() > 128));
		w(`WPS_A_CMD, {29'h0, `WPS_OP_ABORT});
		repeat (3) @(posedge aclk);
		chk("stopped", 32'h0, {31'h0, gen_active});
		host.lag = 1'b0;
	endtask
	task automatic t_script();
		w(`WPS_A_GMODE, 32'h0000_000F);
		pulses = 0;
		sq.delete();
		w(`WPS_A_CMD, {29'h0, `WPS_OP_START});
		repeat (4) @(posedge aclk);
		chk("pulses", 32'h1, 32'(pulses));
		chk("samples", 32'h0, 32'(sq.size()));
		w(`WPS_A_GMODE, 32'h0000_000E);
		w(`WPS_A_RMODE, 32'h0000_0010);
	endtask
	task automatic t_free();
		w(`WPS_A_CMD, {29'h0, `WPS_OP_FREE});
		rc("free", `WPS_A_FREE, 32'h0000_0400);
		w(`WPS_A_CMD, {29'h0, `WPS_OP_FREE});
		err(`WPS_E_FREE);
		w(`WPS_A_DATA, 32'h0000_0001);
		err(`WPS_E_DATA);
	endtask

	// Reset for three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_fill();
		t_finite();
		t_cont();
		t_script();
		t_free();
		close_out();
	end
endmodule
